/* hw/locator_pkg.sv */
package locator_pkg;

   // Byte addresses in the processor's external data space
   localparam logic [15:0] ADDR_COORD = 16'hDF55;
   localparam logic [15:0] ADDR_PARAM = 16'hDF56;
   localparam logic [15:0] ADDR_CTL   = 16'hDF57;
   localparam logic [15:0] ADDR_X     = 16'hDF58;
   localparam logic [15:0] ADDR_Y     = 16'hDF59;
   localparam logic [15:0] ADDR_REV   = 16'hDF60;
   localparam logic [15:0] ADDR_ID    = 16'hDF61;

   // Control/status field positions
   localparam int BIT_EN       = 4;
   localparam int BIT_DONE     = 3;
   localparam int BIT_PARAM_LD = 2;
   localparam int BIT_COORD_LD = 1;
   localparam int BIT_RUN      = 0;

   localparam logic [7:0] RST_BYTE = 8'h00;

   // Load sets: sixteen x/y pairs, and A, n, four bounds, sixteen strengths
   localparam int COORD_SLOTS = 32;
   localparam int PARAM_SLOTS = 22;
   localparam int REF_NODES   = 16;
   localparam int PARAM_XMIN  = 2;
   localparam int PARAM_XSPAN = 3;
   localparam int PARAM_YMIN  = 4;
   localparam int PARAM_YSPAN = 5;
   localparam int PARAM_RSSI0 = 6;

   // Run time from start to completion
   localparam int CLK_PERIOD_NS   = 4;
   localparam int LEAST_RUN_NS    = 50000;
   localparam int LONGEST_RUN_NS  = 13000000;
   localparam int LEAST_RUN_CYC   = (LEAST_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LONGEST_RUN_CYC = LONGEST_RUN_NS / CLK_PERIOD_NS;
   localparam int SPAN_CELLS      = 65536;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } space_req_s;

   typedef enum logic [1:0] {CORE_IDLE, CORE_SCAN, CORE_WAIT} core_state_e;

endpackage

/* hw/locator_core.sv */
`timescale 1ns/10ps
// Stand-in search: picks the strongest reference and paces completion by area
module locator_core #(
   parameter int LEAST_CYC   = locator_pkg::LEAST_RUN_CYC,
   parameter int LONGEST_CYC = locator_pkg::LONGEST_RUN_CYC
) (
   // Clock and reset
   input  wire logic                                            i_clk_sys,
   input  wire logic                                            i_rst,
   input  wire logic                                            i_ce,
   // Control
   input  wire logic                                            i_enable,
   input  wire logic                                            i_start,
   input  wire logic [locator_pkg::COORD_SLOTS-1:0][7:0]        i_coord,
   input  wire logic [locator_pkg::PARAM_SLOTS-1:0][7:0]        i_param,
   // Results
   output logic                                                 o_busy,
   output logic                                                 o_done,
   output logic [7:0]                                           o_x,
   output logic [7:0]                                           o_y
);

   localparam int STEP_CYC = (LONGEST_CYC - LEAST_CYC) / locator_pkg::SPAN_CELLS;

   typedef struct packed {
      locator_pkg::core_state_e state;
      logic [3:0]               idx;
      logic [3:0]               best_idx;
      logic [7:0]               best_rssi;
      logic [31:0]              cnt;
      logic                     done;
      logic [31:0]              age;
      logic [7:0]               x;
      logic [7:0]               y;
   } core_s;

   core_s st_ff;
   core_s nxt_st;
   logic [16:0] cells;
   logic [7:0]  rssi;

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      // Cycles since the run was taken; only the run-time check reads it
      nxt_st.age = (st_ff.state == locator_pkg::CORE_IDLE) ? 32'h1 : st_ff.age + 32'h1;
      cells = 17'((18'(i_param[locator_pkg::PARAM_XSPAN]) + 18'h1)
                * (18'(i_param[locator_pkg::PARAM_YSPAN]) + 18'h1));
      rssi = i_param[locator_pkg::PARAM_RSSI0 + int'(st_ff.idx)];
      unique case (st_ff.state)
         locator_pkg::CORE_IDLE:
         begin
            if (i_start)
            begin
               nxt_st.state = locator_pkg::CORE_SCAN;
               nxt_st.idx = 4'h0;
               nxt_st.best_idx = 4'h0;
               nxt_st.best_rssi = 8'hFF;
               // Scan takes REF_NODES cycles, the wait makes up the rest
               nxt_st.cnt = 32'(LEAST_CYC - locator_pkg::REF_NODES)
                          + 32'(cells) * 32'(STEP_CYC);
            end
         end
         locator_pkg::CORE_SCAN:
         begin
            // Zero strength marks an unused reference slot
            if (rssi != 8'h00 && rssi < st_ff.best_rssi)
            begin
               nxt_st.best_rssi = rssi;
               nxt_st.best_idx = st_ff.idx;
            end
            nxt_st.idx = st_ff.idx + 4'h1;
            if (st_ff.idx == 4'hF)
               nxt_st.state = locator_pkg::CORE_WAIT;
         end
         locator_pkg::CORE_WAIT:
         begin
            nxt_st.cnt = st_ff.cnt - 32'h1;
            if (st_ff.cnt <= 32'h1)
            begin
               nxt_st.state = locator_pkg::CORE_IDLE;
               nxt_st.done = 1'b1;
               // X is one below the point so the modulo correction recovers it
               nxt_st.x = i_coord[{st_ff.best_idx, 1'b0}] - 8'h01;
               nxt_st.y = i_coord[{st_ff.best_idx, 1'b1}];
            end
         end
      endcase
      // Dropping the enable abandons a run short of its last wait cycle; results stay as they were
      if (!i_enable)
         nxt_st.state = locator_pkg::CORE_IDLE;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         st_ff <= '0;
      else if (i_ce)
         st_ff <= nxt_st;
   end

   assign o_busy = st_ff.state != locator_pkg::CORE_IDLE;
   assign o_done = st_ff.done;
   assign o_x    = st_ff.x;
   assign o_y    = st_ff.y;

   a_run_time_bounds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && nxt_st.done) |-> (st_ff.age >= 32'(LEAST_CYC) && st_ff.age <= 32'(LONGEST_CYC)))
      else $error("run time outside bounds");

   a_result_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !(i_ce && nxt_st.done) |=> ($stable(st_ff.x) && $stable(st_ff.y)))
      else $error("result changed without completion");

endmodule

/* hw/location_engine_registers.sv */
`timescale 1ns/10ps
module location_engine_registers #(
   parameter int         LEAST_CYC   = locator_pkg::LEAST_RUN_CYC,
   parameter int         LONGEST_CYC = locator_pkg::LONGEST_RUN_CYC,
   parameter logic [7:0] REV_CODE    = 8'h5A, // Arbitrary value
   parameter logic [7:0] ID_CODE     = 8'hA7  // Arbitrary value
) (
   // Clock, reset, enable
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_rst,
   input  wire logic                    i_ce,
   // Data space access
   input  wire locator_pkg::space_req_s i_bus,
   output logic [7:0]                   o_rdata,
   output logic                         o_rvalid,
   // Status
   output logic                         o_busy
);

   typedef struct packed {
      logic                                         en;
      logic                                         par_ld;
      logic                                         ref_ld;
      logic                                         done;
      logic                                         start;
      logic                                         busy;
      logic [5:0]                                   coord_ptr;
      logic [4:0]                                   par_ptr;
      logic [7:0]                                   coord_last;
      logic [7:0]                                   par_last;
      logic [locator_pkg::COORD_SLOTS-1:0][7:0]     coord;
      logic [locator_pkg::PARAM_SLOTS-1:0][7:0]     param;
      logic [7:0]                                   rdata;
      logic                                         rvalid;
   } regs_s;

   regs_s      st_ff;
   regs_s      nxt_st;
   logic       core_busy;
   logic       core_done;
   logic [7:0] core_x;
   logic [7:0] core_y;
   logic       wr_coord;
   logic       wr_param;
   logic       wr_ctl;
   logic       start_ok;

   function automatic logic hit(input locator_pkg::space_req_s req, input logic [15:0] a);
      hit = req.addr == a;
   endfunction

   function automatic logic [7:0] ctl_byte(input regs_s s);
      ctl_byte = 8'h00;
      ctl_byte[locator_pkg::BIT_EN]       = s.en;
      ctl_byte[locator_pkg::BIT_DONE]     = s.done;
      ctl_byte[locator_pkg::BIT_PARAM_LD] = s.par_ld;
      ctl_byte[locator_pkg::BIT_COORD_LD] = s.ref_ld;
   endfunction

   always_comb
   begin
      wr_coord = i_bus.wr && hit(i_bus, locator_pkg::ADDR_COORD);
      wr_param = i_bus.wr && hit(i_bus, locator_pkg::ADDR_PARAM);
      wr_ctl   = i_bus.wr && hit(i_bus, locator_pkg::ADDR_CTL);
      // A start is ignored unless the same write also sets the enable bit
      start_ok = wr_ctl && i_bus.wdata[locator_pkg::BIT_RUN]
               && i_bus.wdata[locator_pkg::BIT_EN];

      nxt_st = st_ff;
      nxt_st.start = 1'b0;
      nxt_st.busy = core_busy || st_ff.start;

      if (wr_ctl)
      begin
         nxt_st.en = i_bus.wdata[locator_pkg::BIT_EN];
         nxt_st.par_ld = i_bus.wdata[locator_pkg::BIT_PARAM_LD];
         nxt_st.ref_ld = i_bus.wdata[locator_pkg::BIT_COORD_LD];
         if (i_bus.wdata[locator_pkg::BIT_PARAM_LD] && !st_ff.par_ld)
            nxt_st.par_ptr = 5'h0;
         if (i_bus.wdata[locator_pkg::BIT_COORD_LD] && !st_ff.ref_ld)
            nxt_st.coord_ptr = 6'h0;
      end

      // Writes past the last slot are dropped rather than wrapping
      if (wr_coord)
      begin
         nxt_st.coord_last = i_bus.wdata;
         if (st_ff.ref_ld && 32'(st_ff.coord_ptr) < locator_pkg::COORD_SLOTS)
         begin
            nxt_st.coord[st_ff.coord_ptr[4:0]] = i_bus.wdata;
            nxt_st.coord_ptr = st_ff.coord_ptr + 6'h1;
         end
      end
      if (wr_param)
      begin
         nxt_st.par_last = i_bus.wdata;
         if (st_ff.par_ld && 32'(st_ff.par_ptr) < locator_pkg::PARAM_SLOTS)
         begin
            nxt_st.param[st_ff.par_ptr] = i_bus.wdata;
            nxt_st.par_ptr = st_ff.par_ptr + 5'h1;
         end
      end

      // A new start outranks a completion landing in the same cycle
      if (start_ok)
      begin
         nxt_st.start = 1'b1;
         nxt_st.done = 1'b0;
      end
      else if (core_done)
         nxt_st.done = 1'b1;

      nxt_st.rvalid = i_bus.rd;
      if (i_bus.rd)
      begin
         unique case (i_bus.addr)
            locator_pkg::ADDR_COORD: nxt_st.rdata = st_ff.coord_last;
            locator_pkg::ADDR_PARAM: nxt_st.rdata = st_ff.par_last;
            locator_pkg::ADDR_CTL:   nxt_st.rdata = ctl_byte(st_ff);
            locator_pkg::ADDR_X:     nxt_st.rdata = core_x;
            locator_pkg::ADDR_Y:     nxt_st.rdata = core_y;
            locator_pkg::ADDR_REV:   nxt_st.rdata = REV_CODE;
            locator_pkg::ADDR_ID:    nxt_st.rdata = ID_CODE;
            default:                 nxt_st.rdata = locator_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         st_ff <= '0;
      else if (i_ce)
         st_ff <= nxt_st;
   end

   locator_core #(
      .LEAST_CYC   (LEAST_CYC),
      .LONGEST_CYC (LONGEST_CYC)
   ) u_core (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_enable  (st_ff.en),
      .i_start   (st_ff.start),
      .i_coord   (st_ff.coord),
      .i_param   (st_ff.param),
      .o_busy    (core_busy),
      .o_done    (core_done),
      .o_x       (core_x),
      .o_y       (core_y)
   );

   assign o_rdata  = st_ff.rdata;
   assign o_rvalid = st_ff.rvalid;
   assign o_busy   = st_ff.busy;

   a_ctl_rsv_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && i_bus.rd && i_bus.addr == locator_pkg::ADDR_CTL)
      |=> (o_rvalid && o_rdata[7:5] == 3'h0 && !o_rdata[locator_pkg::BIT_RUN]))
      else $error("control reserved or start bit read nonzero");

   a_id_fixed: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && i_bus.rd && i_bus.addr == locator_pkg::ADDR_ID) |=> (o_rdata == ID_CODE))
      else $error("identification read wrong");

   a_rev_fixed: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && i_bus.rd && i_bus.addr == locator_pkg::ADDR_REV) |=> (o_rdata == REV_CODE))
      else $error("revision read wrong");

   a_x_readback: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && i_bus.rd && i_bus.addr == locator_pkg::ADDR_X) |=> (o_rdata == $past(core_x)))
      else $error("x result read wrong");

   a_done_clears: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && start_ok) |=> (!st_ff.done && st_ff.start) ##1 (!i_ce || st_ff.busy))
      else $error("start did not clear done and launch");

   a_start_gated: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && wr_ctl && !i_bus.wdata[locator_pkg::BIT_EN]) |=> (!st_ff.start && !st_ff.en))
      else $error("start taken while disabled");

   a_ptr_restart: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && wr_ctl && i_bus.wdata[locator_pkg::BIT_COORD_LD] && !st_ff.ref_ld && !wr_coord)
      |=> (st_ff.coord_ptr == 6'h0 && st_ff.ref_ld))
      else $error("coordinate counter did not restart");

   a_ptr_advance: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && wr_param && st_ff.par_ld && 32'(st_ff.par_ptr) < locator_pkg::PARAM_SLOTS)
      |=> (st_ff.par_ptr == $past(st_ff.par_ptr) + 5'h1
           && st_ff.param[$past(st_ff.par_ptr)] == $past(i_bus.wdata)))
      else $error("parameter write not stored in order");

   a_coord_store: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && wr_coord && st_ff.ref_ld && 32'(st_ff.coord_ptr) < locator_pkg::COORD_SLOTS)
      |=> (st_ff.coord_ptr == $past(st_ff.coord_ptr) + 6'h1
           && st_ff.coord[$past(st_ff.coord_ptr[4:0])] == $past(i_bus.wdata)))
      else $error("coordinate write not stored in order");

   a_done_sets: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && core_done && !start_ok) |=> st_ff.done)
      else $error("completion did not set done");

   a_y_readback: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && i_bus.rd && i_bus.addr == locator_pkg::ADDR_Y) |=> (o_rdata == $past(core_y)))
      else $error("y result read wrong");

endmodule

/* tb/location_engine_registers_test.sv */
`timescale 1ns/10ps
module location_engine_registers_test;
   // Short run time; equal bounds make the search-area step zero
   localparam int T_RUN = 20;
   localparam logic [7:0] T_REV = 8'h3C; // Arbitrary value
   localparam logic [7:0] T_ID  = 8'hC3; // Arbitrary value
   logic                    i_clk_sys;
   logic                    i_rst;
   logic                    i_ce;
   locator_pkg::space_req_s i_bus;
   logic [7:0]              o_rdata;
   logic                    o_rvalid;
   logic                    o_busy;
   logic [7:0]              exp_q[$];
   logic [7:0]              coord[32];
   logic [7:0]              rssi[16];
   logic [15:0]             reg_addr[7];
   logic [7:0]              reg_rst[7];
   logic [7:0]              ex_x;
   logic [7:0]              ex_y;
   int                      error_cnt;
   int                      check_count;
   int                      cycles;
   int                      busy_len;

   location_engine_registers #(
      .LEAST_CYC   (T_RUN),
      .LONGEST_CYC (T_RUN),
      .REV_CODE    (T_REV),
      .ID_CODE     (T_ID)
   ) dut (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_bus     (i_bus),
      .o_rdata   (o_rdata),
      .o_rvalid  (o_rvalid),
      .o_busy    (o_busy)
   );

   initial
   begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] expd);
      check_count++;
      if (seen !== expd)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expd);
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // One strobe cycle, then an idle cycle, so no signal is driven twice per step
   task automatic access(input logic w, input logic r, input logic [15:0] a,
                         input logic [7:0] d);
      @(posedge i_clk_sys);
      i_bus <= '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge i_clk_sys);
      i_bus <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: d};
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      access(1'b1, 1'b0, a, d);
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] expd);
      exp_q.push_back(expd);
      access(1'b0, 1'b1, a, 8'h00);
   endtask

   // Read results are matched in issue order against the noted expectations
   always @(negedge i_clk_sys)
   begin
      if (o_rvalid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check({7'h00, o_rvalid}, 8'h00);
         else
            check(o_rdata, exp_q.pop_front());
      end
   end

   always @(posedge i_clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end

   task automatic read_all();
      for (int i = 0; i < 7; i++)
         rd(reg_addr[i], reg_rst[i]);
   endtask

   task automatic load_coords();
      wr(locator_pkg::ADDR_CTL, 8'h12);
      for (int i = 0; i < 32; i++)
      begin
         coord[i] = 8'($urandom);
         wr(locator_pkg::ADDR_COORD, coord[i]);
      end
      wr(locator_pkg::ADDR_CTL, 8'h10);
   endtask

   // Unused strength slots are zero; the strongest reference is the smallest nonzero
   task automatic load_params(input int used);
      int best;
      best = -1;
      wr(locator_pkg::ADDR_CTL, 8'h14);
      for (int i = 0; i < 6; i++)
         wr(locator_pkg::ADDR_PARAM, 8'($urandom));
      for (int k = 0; k < 16; k++)
      begin
         rssi[k] = (k < used) ? 8'(1 + $urandom % 200) : 8'h00;
         wr(locator_pkg::ADDR_PARAM, rssi[k]);
         if (rssi[k] != 8'h00 && (best < 0 || rssi[k] < rssi[best]))
            best = k;
      end
      // A write past the last slot must not disturb the stored set
      wr(locator_pkg::ADDR_PARAM, 8'h01);
      wr(locator_pkg::ADDR_CTL, 8'h10);
      if (best < 0)
         best = 0;
      ex_x = coord[2 * best] - 8'h01;
      ex_y = coord[2 * best + 1];
   endtask

   task automatic run_and_check();
      wr(locator_pkg::ADDR_CTL, 8'h11);
      rd(locator_pkg::ADDR_CTL, 8'h10);
      busy_len = 0;
      for (int i = 0; i < 4 * T_RUN; i++)
      begin
         @(negedge i_clk_sys);
         if (o_busy === 1'b1)
            busy_len++;
         else if (busy_len > 0)
            break;
      end
      check(8'(busy_len >= T_RUN - 6 && busy_len <= T_RUN + 2), 8'h01);
      rd(locator_pkg::ADDR_CTL, 8'h18);
      rd(locator_pkg::ADDR_X, ex_x);
      rd(locator_pkg::ADDR_Y, ex_y);
   endtask

   initial
   begin
      i_rst = 1'b1;
      i_ce = 1'b1;
      i_bus = '0;
      error_cnt = 0;
      check_count = 0;
      cycles = 0;
      reg_addr = '{locator_pkg::ADDR_COORD, locator_pkg::ADDR_PARAM, locator_pkg::ADDR_CTL,
                   locator_pkg::ADDR_X, locator_pkg::ADDR_Y, locator_pkg::ADDR_REV,
                   locator_pkg::ADDR_ID};
      reg_rst = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, T_REV, T_ID};
      void'($urandom(73));
      repeat (20) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      read_all();
      rd(16'hDF5A, 8'h00);
      rd(16'hDF54, 8'h00);
      // Read-only places ignore writes; start with enable low is ignored
      for (int i = 3; i < 7; i++)
         wr(reg_addr[i], 8'($urandom));
      wr(16'hDF5A, 8'hFF);
      wr(locator_pkg::ADDR_CTL, 8'hE1);
      rd(locator_pkg::ADDR_CTL, 8'h00);
      for (int i = 3; i < 7; i++)
         rd(reg_addr[i], reg_rst[i]);
      wr(locator_pkg::ADDR_CTL, 8'h10);
      rd(locator_pkg::ADDR_CTL, 8'h10);
      load_coords();
      rd(locator_pkg::ADDR_COORD, coord[31]);
      load_params(12);
      rd(locator_pkg::ADDR_CTL, 8'h10);
      run_and_check();
      // Stray port write with flags low; results must hold
      wr(locator_pkg::ADDR_COORD, 8'($urandom));
      rd(locator_pkg::ADDR_X, ex_x);
      rd(locator_pkg::ADDR_Y, ex_y);
      // Reloading must restart both write positions
      load_coords();
      load_params(16);
      run_and_check();
      // Abort by dropping enable: done stays low, x result kept
      wr(locator_pkg::ADDR_CTL, 8'h11);
      wr(locator_pkg::ADDR_CTL, 8'h00);
      repeat (2 * T_RUN) @(posedge i_clk_sys);
      rd(locator_pkg::ADDR_CTL, 8'h00);
      rd(locator_pkg::ADDR_X, ex_x);
      // Reset in mid-run clears everything
      wr(locator_pkg::ADDR_CTL, 8'h11);
      @(posedge i_clk_sys);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      read_all();
      // A read with the clock enable low gets no answer
      @(posedge i_clk_sys);
      i_ce <= 1'b0;
      access(1'b0, 1'b1, locator_pkg::ADDR_ID, 8'h00);
      i_ce <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      check(8'(exp_q.size()), 8'h00);
      report_and_stop();
   end
endmodule
